// ==== src/adc_seq_consts.vh ====
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

`define OFS_MODE 8'h00
`define OFS_INSEL 8'h04
`define OFS_CTRL0 8'h08
`define OFS_CTRL1 8'h0c
`define OFS_GAIN 8'h10
`define OFS_RESULT 8'h20
`define OFS_RESULT_LAST 8'h3c

`define MODE_ONESHOT 3'h0
`define MODE_REP0 3'h2
`define MODE_REP1 3'h3
`define MODE_SWEEP 3'h4
`define MODE_REPSWEEP 3'h6

`define TRIG_SW 2'h0
`define TRIG_TIMER 2'h1
`define TRIG_COMPARE 2'h2
`define TRIG_EXT 2'h3

`define START_CYC_DIV1 3'h2
`define START_CYC_DIV2 3'h3
`define START_CYC_DIV4 3'h4
`define START_CYC_DIV8 3'h6
`define CONV_PHI_PLAIN 6'd40
`define CONV_PHI_ASSIST 6'd42
`define ASSIST_PHI 6'd2
`define TAIL_CYC 2'h2
`define END_CYC 2'h2

`endif

// ==== src/adc_phi_div.v ====
`timescale 1ns/1ps
// conversion clock enable: one pulse every 1, 2, 4 or 8 base cycles
module adc_phi_div (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // control
  input wire [1:0] divSel,
  input wire restart,
  // enable out
  output reg phiTick
);
  reg [2:0] cnt_q;
  wire [2:0] limit = (3'h1 << divSel) - 3'h1;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 3'h0;
      phiTick <= 1'b0;
    end else if (restart) begin
      cnt_q <= 3'h0;
      phiTick <= (limit == 3'h0);
    end else begin
      if (cnt_q >= limit) begin
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
      // tick stands in the cycle in which the counter sits at its limit
      phiTick <= (cnt_q >= limit) ? (limit == 3'h0) : (cnt_q + 3'h1 == limit);
    end
  end
endmodule // adc_phi_div

// ==== src/adc_conversion_sequencer.v ====
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_conversion_sequencer (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // axi4-lite write address, data and response
  input wire awvalid,
  output reg awready,
  input wire [7:0] awaddr,
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // axi4-lite read
  input wire arvalid,
  output reg arready,
  input wire [7:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // trigger sources
  input wire firstTimerFlag,
  input wire firstTimerIrqEnable,
  input wire [2:0] priorityLevel,
  input wire [3:0] matchFlag,
  input wire [3:0] channelTriggerEnable,
  input wire compareOutputMode,
  input wire externalTriggerPin,
  input wire extInputEnable,
  input wire portDirectionBit,
  // analog front end
  input wire [9:0] convData,
  output reg [2:0] anaChan,
  output reg anaRefSel,
  output reg [2:0] gainSel,
  output reg anaPowerOn,
  output reg convRun,
  output reg assistActive,
  output reg assistLevel,
  output reg tenBitMode,
  // conversion request
  output reg convIrq
);
  localparam S_IDLE = 6'h01;
  localparam S_START = 6'h02;
  localparam S_CONV = 6'h04;
  localparam S_TAIL = 6'h08;
  localparam S_GAP = 6'h10;
  localparam S_END = 6'h20;

  reg [5:0] state_q;
  reg [7:0] modeReg_q;
  reg [7:0] inselReg_q;
  reg [7:0] ctrl1_q;
  reg [2:0] gain_q;
  reg startFlag_q;
  reg [2:0] startCnt_q;
  reg [5:0] phiCnt_q;
  reg [1:0] tailCnt_q;
  reg [2:0] slot_q;
  reg [9:0] convHold_q;
  reg [2:0] holdIdx_q;
  reg timerPrev_q;
  reg [3:0] matchPrev_q;
  reg pinPrev_q;
  reg phiRestart_q;
  reg awHave_q;
  reg wHave_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg [9:0] result [0:7];

  wire phiTick;
  wire [2:0] mode = modeReg_q[5:3];
  wire [1:0] trigSel = modeReg_q[7:6];
  wire [1:0] divSel = modeReg_q[1:0];
  wire [1:0] sweepCnt = inselReg_q[5:4];
  wire [2:0] chSel = inselReg_q[2:0];
  wire sweepMode = (mode == `MODE_SWEEP) || (mode == `MODE_REPSWEEP);
  wire rep1Mode = (mode == `MODE_REP1);
  wire repeatMode = (mode == `MODE_REP0) || rep1Mode || (mode == `MODE_REPSWEEP);
  wire assistOn = ctrl1_q[6];
  wire refOn = ctrl1_q[0] && !sweepMode;
  wire running = !state_q[0] && !state_q[1];
  wire wrFire = awHave_q && wHave_q && !bvalid;
  wire wrCtrl0 = wrFire && (awAddr_q == `OFS_CTRL0) && wStrb_q[0];

  // edge detectors on the trigger inputs
  wire timerRise = firstTimerFlag && !timerPrev_q && firstTimerIrqEnable &&
    (priorityLevel == 3'h0);
  wire compareRise = compareOutputMode &&
    (|(matchFlag & ~matchPrev_q & channelTriggerEnable));
  wire pinFall = !externalTriggerPin && pinPrev_q && extInputEnable &&
    !portDirectionBit;
  reg trigFire;
  always @* begin
    case (trigSel)
      `TRIG_SW: trigFire = 1'b1;
      `TRIG_TIMER: trigFire = timerRise;
      `TRIG_COMPARE: trigFire = compareRise;
      default: trigFire = pinFall;
    endcase
  end

  reg [2:0] startLen;
  always @* begin
    case (divSel)
      2'h0: startLen = `START_CYC_DIV1;
      2'h1: startLen = `START_CYC_DIV2;
      2'h2: startLen = `START_CYC_DIV4;
      default: startLen = `START_CYC_DIV8;
    endcase
  end

  // last slot index: sweep of 7 pins runs 8 slots
  reg [2:0] lastSlot;
  always @* begin
    if (sweepMode) begin
      case (sweepCnt)
        2'h0: lastSlot = 3'h1;
        2'h1: lastSlot = 3'h3;
        2'h2: lastSlot = 3'h5;
        default: lastSlot = 3'h7;
      endcase
    end else if (rep1Mode) begin
      lastSlot = 3'h7;
    end else begin
      lastSlot = 3'h0;
    end
  end

  wire [5:0] convLen = assistOn ? `CONV_PHI_ASSIST : `CONV_PHI_PLAIN;
  // a tick left over from before the divider restart is not a conversion cycle
  wire convDone = state_q[2] && phiTick && !phiRestart_q && (phiCnt_q == convLen - 6'd1);
  wire tailDone = state_q[3] && (tailCnt_q == `TAIL_CYC - 2'h1);
  wire endDone = state_q[5] && (tailCnt_q == `END_CYC - 2'h1);
  wire lastNow = (slot_q == lastSlot);
  wire deferLast = lastNow && !repeatMode;
  wire dummySlot = sweepMode && (sweepCnt == 2'h3) && (slot_q == 3'h7);
  wire [2:0] slotIdx = (sweepMode || rep1Mode) ? slot_q : (refOn ? 3'h0 : chSel);
  wire resWe = (tailDone && !deferLast && !dummySlot) || endDone;
  wire [2:0] resIdx = endDone ? holdIdx_q : slotIdx;
  wire [9:0] resData = endDone ? convHold_q : convData;

  adc_phi_div phiDiv (
    .mclk(mclk),
    .rstn(rstn),
    .divSel(divSel),
    .restart(phiRestart_q),
    .phiTick(phiTick)
  );

  // result store has no reset and no bus write path
  always @(posedge mclk) begin
    if (resWe) begin
      result[resIdx] <= resData;
    end
  end

  // register file and start flag
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      modeReg_q <= 8'h00;
      inselReg_q <= 8'h00;
      ctrl1_q <= 8'h00;
      gain_q <= 3'h0;
      startFlag_q <= 1'b0;
    end else begin
      if (wrFire && wStrb_q[0]) begin
        case (awAddr_q)
          `OFS_MODE: modeReg_q <= {wData_q[7:3], 1'b0, wData_q[1:0]};
          `OFS_INSEL: inselReg_q <= {2'h0, wData_q[5:4], 1'b0, wData_q[2:0]};
          `OFS_CTRL1: ctrl1_q <= {wData_q[7:4], 3'h0, wData_q[0]};
          `OFS_GAIN: gain_q <= wData_q[2:0];
          default: ;
        endcase
      end
      if (wrCtrl0) begin
        startFlag_q <= wData_q[0];
      end else if (endDone) begin
        startFlag_q <= 1'b0;
      end
    end
  end

  // sequencer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      startCnt_q <= 3'h0;
      phiCnt_q <= 6'h00;
      tailCnt_q <= 2'h0;
      slot_q <= 3'h0;
      convHold_q <= 10'h000;
      holdIdx_q <= 3'h0;
      timerPrev_q <= 1'b0;
      matchPrev_q <= 4'h0;
      pinPrev_q <= 1'b1;
      phiRestart_q <= 1'b0;
      convIrq <= 1'b0;
    end else begin
      timerPrev_q <= firstTimerFlag;
      matchPrev_q <= matchFlag;
      pinPrev_q <= externalTriggerPin;
      phiRestart_q <= 1'b0;
      convIrq <= 1'b0;
      if (!startFlag_q && !state_q[0]) begin
        state_q <= S_IDLE;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (startFlag_q && trigFire) begin
              state_q <= S_START;
              startCnt_q <= startLen;
              slot_q <= 3'h0;
            end
          end
          S_START: begin
            startCnt_q <= startCnt_q - 3'h1;
            if (startCnt_q == 3'h1) begin
              state_q <= S_CONV;
              phiCnt_q <= 6'h00;
              phiRestart_q <= 1'b1;
            end
          end
          S_CONV: begin
            if (phiTick && !phiRestart_q) begin
              phiCnt_q <= phiCnt_q + 6'h01;
            end
            if (convDone) begin
              state_q <= S_TAIL;
              tailCnt_q <= 2'h0;
            end
          end
          S_TAIL: begin
            tailCnt_q <= tailCnt_q + 2'h1;
            if (tailDone) begin
              convHold_q <= convData;
              holdIdx_q <= slotIdx;
              tailCnt_q <= 2'h0;
              if (deferLast) begin
                state_q <= S_END;
              end else begin
                state_q <= S_GAP;
                phiRestart_q <= 1'b1;
                if (lastNow) begin
                  slot_q <= 3'h0;
                  convIrq <= (mode != `MODE_REP0);
                end else begin
                  slot_q <= slot_q + 3'h1;
                end
              end
            end
          end
          S_GAP: begin
            if (phiTick && !phiRestart_q) begin
              state_q <= S_CONV;
              phiCnt_q <= 6'h00;
            end
          end
          S_END: begin
            tailCnt_q <= tailCnt_q + 2'h1;
            if (endDone) begin
              state_q <= S_IDLE;
              convIrq <= 1'b1;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // analog front-end controls
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      anaChan <= 3'h0;
      anaRefSel <= 1'b0;
      gainSel <= 3'h0;
      anaPowerOn <= 1'b0;
      convRun <= 1'b0;
      assistActive <= 1'b0;
      assistLevel <= 1'b0;
      tenBitMode <= 1'b0;
    end else begin
      anaChan <= sweepMode ? slot_q : chSel;
      anaRefSel <= refOn;
      gainSel <= gain_q;
      anaPowerOn <= ctrl1_q[5];
      convRun <= state_q[2];
      assistActive <= state_q[2] && assistOn && (phiCnt_q < `ASSIST_PHI);
      assistLevel <= ctrl1_q[7];
      tenBitMode <= ctrl1_q[4];
    end
  end

  // axi4-lite slave
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (wrFire) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddr_q[1:0] != 2'h0 || awAddr_q > `OFS_RESULT_LAST ||
          (awAddr_q > `OFS_GAIN && awAddr_q < `OFS_RESULT)) ? 2'h2 : 2'h0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= 2'h0;
        rdata <= 32'h0000_0000;
        if (araddr[1:0] != 2'h0) begin
          rresp <= 2'h2;
        end else if (araddr >= `OFS_RESULT && araddr <= `OFS_RESULT_LAST) begin
          rdata <= {22'h0, result[araddr[4:2]]};
        end else begin
          case (araddr)
            `OFS_MODE: rdata <= {24'h0, modeReg_q};
            `OFS_INSEL: rdata <= {24'h0, inselReg_q};
            `OFS_CTRL0: rdata <= {31'h0, startFlag_q && running};
            `OFS_CTRL1: rdata <= {24'h0, ctrl1_q};
            `OFS_GAIN: rdata <= {29'h0, gain_q};
            default: rresp <= 2'h2;
          endcase
        end
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // adc_conversion_sequencer

// ==== bench/adc_seq_assertions.sv ====
`timescale 1ns/1ps
module adc_seq_assertions (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // register bus
  input wire awready,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [7:0] araddr,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  // converter
  input wire convRun,
  input wire assistActive,
  input wire convIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  chk_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write ready while response pending");
  chk_read_busy: assert property (rvalid |-> !arready)
    else $error("read ready while data pending");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  chk_read_unmapped: assert property (arvalid && arready && (araddr > 8'h3c ||
    araddr[1:0] != 2'h0) |=> rresp == 2'h2) else $error("bad address not refused");
  chk_irq_pulse: assert property (convIrq |=> !convIrq)
    else $error("request longer than one cycle");
  chk_run_min: assert property ($rose(convRun) |-> convRun[*8])
    else $error("conversion too short");
  chk_assist_window: assert property ($rose(assistActive) |-> ##[1:20] !assistActive)
    else $error("assist phase too long");
endmodule // adc_seq_assertions

bind adc_conversion_sequencer adc_seq_assertions chk (.mclk(mclk), .rstn(rstn),
  .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .convRun(convRun), .assistActive(assistActive), .convIrq(convIrq));

// ==== bench/adc_far_side.sv ====
`timescale 1ns/1ps
module adc_far_side (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // stimulus request
  input wire fire,
  input wire [1:0] fireSel,
  input wire [2:0] anaChan,
  // trigger sources and analog value
  output logic firstTimerFlag,
  output logic [3:0] matchFlag,
  output logic externalTriggerPin,
  output logic [9:0] convData
);
  logic [2:0] holdQ;
  // each source shows its event for a few cycles, then returns to idle
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      holdQ <= 3'h0;
      firstTimerFlag <= 1'b0;
      matchFlag <= 4'h0;
      externalTriggerPin <= 1'b1;
    end else if (fire) begin
      holdQ <= 3'h4;
      firstTimerFlag <= (fireSel == 2'h1);
      matchFlag <= {3'h0, fireSel == 2'h2};
      externalTriggerPin <= (fireSel != 2'h3);
    end else if (holdQ != 3'h0) begin
      holdQ <= holdQ - 3'h1;
    end else begin
      firstTimerFlag <= 1'b0;
      matchFlag <= 4'h0;
      externalTriggerPin <= 1'b1;
    end
  end
  // value tells which input was converted
  assign convData = {anaChan, 7'h2a};
endmodule // adc_far_side

// ==== bench/adc_conversion_sequencer_test.sv ====
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r; bit rb;} row_t;
  logic mclk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, fire = 1'b0, timerEn = 1'b0, cmpMode = 1'b0;
  logic extEn = 1'b0, portDir = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'hf, chanTrig = 4'h0;
  logic [2:0] prio = 3'h7;
  logic [1:0] fireSel = 2'h0, rsp;
  wire awready, wready, bvalid, arready, rvalid, timerFlag, extPin, refSel, pwr, convRun;
  wire assistActive, assistLevel, tenBit, convIrq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] matchFlag;
  wire [9:0] convData;
  wire [2:0] anaChan, gainSel;
  int failCount = 0, numChecks = 0, cycles = 0, irqs = 0, n, k, dv;
  row_t rows[7] = '{'{8'h00, 32'h22, 32'h22, 2'h0, 1}, '{8'h04, 32'h35, 32'h35, 2'h0, 1},
    '{8'h0c, 32'hf1, 32'hf1, 2'h0, 1}, '{8'h10, 32'h4, 32'h4, 2'h0, 1},
    '{8'h20, 32'h3ff, 32'h0, 2'h0, 0}, '{8'h40, 32'h1, 32'h0, 2'h2, 1},
    '{8'h02, 32'h1, 32'h0, 2'h2, 1}};

  adc_conversion_sequencer dut (.mclk(mclk), .rstn(rstn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .firstTimerFlag(timerFlag), .firstTimerIrqEnable(timerEn),
    .priorityLevel(prio), .matchFlag(matchFlag), .channelTriggerEnable(chanTrig),
    .compareOutputMode(cmpMode), .externalTriggerPin(extPin), .extInputEnable(extEn),
    .portDirectionBit(portDir), .convData(convData), .anaChan(anaChan), .anaRefSel(refSel),
    .gainSel(gainSel), .anaPowerOn(pwr), .convRun(convRun), .assistActive(assistActive),
    .assistLevel(assistLevel), .tenBitMode(tenBit), .convIrq(convIrq));
  adc_far_side far (.mclk(mclk), .rstn(rstn), .fire(fire), .fireSel(fireSel),
    .anaChan(anaChan), .firstTimerFlag(timerFlag), .matchFlag(matchFlag),
    .externalTriggerPin(extPin), .convData(convData));

  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (convIrq) irqs <= irqs + 1;
    if (cycles == 20000) begin
      failCount++;
      conclude();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("checks=%0d failures=%0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task rdReg(input logic [7:0] a);
    @(posedge mclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata; rsp = rresp;
    rready <= 1'b0;
  endtask

  // standby enabled by earlier writes, well ahead of the start flag
  task conv(input logic [31:0] md, input logic [31:0] ins, input logic [31:0] c1,
            input logic [1:0] fs, input int lim);
    wr(8'h0c, c1);
    wr(8'h00, md);
    wr(8'h04, ins);
    wr(8'h08, 32'h1);
    if (fs != 2'h0) begin
      rdReg(8'h08); check(rd, 32'h0);
      fire <= 1'b1; fireSel <= fs;
      @(posedge mclk);
      fire <= 1'b0;
    end
    n = 0;
    while (!convIrq && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rdReg(8'h00); check(rd, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d); check(rsp, rows[i].r);
      if (rows[i].rb) begin
        rdReg(rows[i].a); check(rsp, rows[i].r);
        if (rows[i].r == 2'h0) check(rd, rows[i].e);
      end
    end
    // sweep mode set by the rows, so the reference input stays off
    check({gainSel, pwr, assistLevel, tenBit, refSel}, 32'h4e);
    for (int d = 0; d < 5; d++) begin
      dv = 1 << (d % 4);
      k = (d == 4) ? 42 : 40;
      conv(32'(d % 4), 32'h3, (d == 4) ? 32'h70 : 32'h30, 2'h0, 3000);
      check(n >= k * dv && n <= (k + 2) * dv + 12, 1);
      rdReg(8'h08); check(rd, 32'h0);
      rdReg(8'h2c); check(rd, 32'h1aa);
    end
    conv(32'h0, 32'h3, 32'h31, 2'h0, 3000);
    check(refSel, 1);
    rdReg(8'h20); check(rd, 32'h1aa);
    wr(8'h20, 32'h0);
    rdReg(8'h20); check(rd, 32'h1aa);
    conv(32'h20, 32'h30, 32'h30, 2'h0, 3000);
    check(n >= 8 * 42 && n <= 8 * 42 + 20, 1);
    for (int i = 0; i < 7; i++) begin
      rdReg(8'h20 + 8'(4 * i)); check(rd, {22'h0, 3'(i), 7'h2a});
    end
    conv(32'h10, 32'h5, 32'h30, 2'h0, 600);
    check(n, 600);
    rdReg(8'h08); check(rd, 32'h1);
    k = irqs;
    wr(8'h08, 32'h0);
    repeat (100) @(posedge mclk);
    check(irqs == k && !convRun, 1);
    conv(32'h18, 32'h2, 32'h30, 2'h0, 3000);
    check(n < 3000, 1);
    rdReg(8'h08); check(rd, 32'h1);
    // abort well inside the next conversion, not at its first cycles
    repeat (20) @(posedge mclk);
    wr(8'h08, 32'h0);
    prio <= 3'h0; timerEn <= 1'b1; cmpMode <= 1'b1; chanTrig <= 4'h1;
    extEn <= 1'b1; portDir <= 1'b0;
    for (int t = 1; t < 4; t++) begin
      conv(32'(t << 6), 32'h3, 32'h30, 2'(t), 3000);
      check(n < 3000, 1);
      wr(8'h08, 32'h0);
    end
    conclude();
  end
endmodule // adc_conversion_sequencer_test
